/* File: design/msp_core.sv */
// Contract
// - straps decode into four link mode sets
// - register writes override descrambler and NRZI defaults
// - DC-balance uses four lanes, fifth is valid
// - sync character drives data low, valid high
// - code error drives data high, valid high
// - no-sense no-balance mode keeps no alignment
// - respond only while select input high
// - management port stays active in standby
// - target address is 1011000, byte B0
// - write: address, register, data, all acknowledged
// - read: register, repeated start, read data
// - acknowledge bytes by driving acknowledge low
// - start and stop are SDA edges, SCK high
// - descrambler override needs unlock bit first
// - idle is K28.5 plus one programmable character
//
// Mode strap decode, DC-balance output coding and management bus target.
// Assumes decoded lane symbols arrive on the core clock; bus pins are asynchronous.
`timescale 1ns/1ps
module msp_core (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_REMOTE_SENSE_DISABLE_N,
  input wire logic I_DC_BALANCE_DISABLE_N,
  input wire logic I_MGMT_PORT_SELECT,
  input wire logic I_STANDBY,
  input wire logic I_SCK,
  input wire logic I_SDA,
  input wire logic [4:0] I_RAW_LANES,
  input wire logic [7:0] I_DEC_BYTE,
  input wire logic I_DEC_IS_K,
  input wire logic I_DEC_ERR,
  input wire logic I_DEC_STB,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  output logic [4:0] O_LANES,
  output logic O_REMOTE_SENSE_EN,
  output logic O_DC_BALANCE_EN,
  output logic O_ALIGN_EN,
  output logic O_DESCR_EN,
  output logic O_NRZI_EN
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic sck_s; // Synchronised bus clock
  logic sda_s; // Synchronised bus data
  logic sel_s; // Synchronised select
  msp_sync u_sck (.i_clk(I_CORE_CLK), .i_rst_n(I_RST_N), .i_async(I_SCK), .o_sync(sck_s));
  msp_sync u_sda (.i_clk(I_CORE_CLK), .i_rst_n(I_RST_N), .i_async(I_SDA), .o_sync(sda_s));
  msp_sync u_sel (.i_clk(I_CORE_CLK), .i_rst_n(I_RST_N), .i_async(I_MGMT_PORT_SELECT), .o_sync(sel_s));
  logic sense_dis_s; // Synchronised remote sense strap
  logic bal_dis_s; // Synchronised DC-balance strap
  // Strap stages skip reset so the levels settle while reset is held
  msp_sync u_strap_sense (.i_clk(I_CORE_CLK), .i_rst_n(1'b1), .i_async(I_REMOTE_SENSE_DISABLE_N),
    .o_sync(sense_dis_s));
  msp_sync u_strap_bal (.i_clk(I_CORE_CLK), .i_rst_n(1'b1), .i_async(I_DC_BALANCE_DISABLE_N),
    .o_sync(bal_dis_s));

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture and mode decode
  logic strap_done_q; // Straps caught once after reset
  logic sense_dis_q; // Remote sense disable strap
  logic dc_dis_q; // DC-balance disable strap
  // Straps caught on the first edge after release, never under reset
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      strap_done_q <= 1'b0;
      sense_dis_q <= 1'b1;
      dc_dis_q <= 1'b1;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      sense_dis_q <= sense_dis_s;
      dc_dis_q <= bal_dis_s;
    end
  end

  logic decoders_dflt; // Descrambler and NRZI default
  assign decoders_dflt = sense_dis_q ^ dc_dis_q;

  // Override registers: held until reset
  logic [7:0] unlock_q; // Unlock bits per decoder
  logic [7:0] ctrl_q; // Written enables
  logic [7:0] idle_q; // Programmable idle character
  logic descr_ovr_q; // Descrambler override valid
  logic nrzi_ovr_q; // NRZI override valid

  // Mode outputs registered
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_REMOTE_SENSE_EN <= 1'b0;
      O_DC_BALANCE_EN <= 1'b0;
      O_ALIGN_EN <= 1'b0;
      O_DESCR_EN <= 1'b0;
      O_NRZI_EN <= 1'b0;
    end else begin
      O_REMOTE_SENSE_EN <= !sense_dis_q;
      O_DC_BALANCE_EN <= !dc_dis_q;
      O_ALIGN_EN <= !(sense_dis_q && dc_dis_q);
      O_DESCR_EN <= descr_ovr_q ? ctrl_q[pkg_descr()] : decoders_dflt;
      O_NRZI_EN <= nrzi_ovr_q ? ctrl_q[pkg_nrzi()] : decoders_dflt;
    end
  end

  function automatic int pkg_descr();
    return msp_pkg::MSP_BIT_DESCR;
  endfunction : pkg_descr
  function automatic int pkg_nrzi();
    return msp_pkg::MSP_BIT_NRZI;
  endfunction : pkg_nrzi

  ////////////////////////////////////////////////////////////////////////////
  // Lane output coding
  // In DC-balance mode the fifth lane is data valid
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_LANES <= 5'h00;
    end else if (dc_dis_q) begin
      O_LANES <= I_RAW_LANES; // Plain five-lane output
    end else if (I_DEC_STB) begin
      if (I_DEC_ERR) begin
        O_LANES <= 5'h1F;
      end else if (I_DEC_IS_K && (I_DEC_BYTE == msp_pkg::MSP_IDLE_RST || I_DEC_BYTE == idle_q)) begin
        O_LANES <= 5'h10;
      end else begin
        O_LANES <= {1'b0, I_DEC_BYTE[3:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition detection
  logic sck_d1_q; // Previous bus clock
  logic sda_d1_q; // Previous bus data
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      sck_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      sck_d1_q <= sck_s;
      sda_d1_q <= sda_s;
    end
  end
  logic sck_rise; // Sample point
  logic sck_fall; // Drive point
  logic start_cond; // SDA falls while SCK high
  logic stop_cond; // SDA rises while SCK high
  assign sck_rise = sck_s && !sck_d1_q;
  assign sck_fall = !sck_s && sck_d1_q;
  assign start_cond = sck_s && sck_d1_q && sda_d1_q && !sda_s;
  assign stop_cond = sck_s && sck_d1_q && !sda_d1_q && sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Target protocol engine; standby does not gate it
  msp_pkg::msp_state_type state_q;
  logic [3:0] bit_cnt_q; // Bits taken in current byte
  logic [7:0] shift_q; // Byte shifter
  logic [7:0] reg_addr_q; // Register pointer
  logic [1:0] byte_idx_q; // 0 address, 1 pointer, 2 data
  logic is_read_q; // Current phase is a read
  logic ack_pend_q; // Unused; cleared at reset and never set or read

  // Register read mux
  logic [7:0] rd_data; // Contents at pointer
  always_comb begin
    rd_data = 8'h00;
    if (reg_addr_q == msp_pkg::MSP_REG_CTRL) begin
      rd_data = ctrl_q;
    end else if (reg_addr_q == msp_pkg::MSP_REG_UNLOCK) begin
      rd_data = unlock_q;
    end else if (reg_addr_q == msp_pkg::MSP_REG_IDLE_CHAR) begin
      rd_data = idle_q;
    end else if (reg_addr_q == msp_pkg::MSP_REG_STATUS) begin
      rd_data = {3'h0, O_NRZI_EN, O_DESCR_EN, I_STANDBY, O_DC_BALANCE_EN, O_REMOTE_SENSE_EN};
    end
  end

  // Protocol state; deselect aborts and releases the line
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      state_q <= msp_pkg::MSP_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      reg_addr_q <= 8'h00;
      byte_idx_q <= 2'h0;
      is_read_q <= 1'b0;
      ack_pend_q <= 1'b0;
      O_SDA_OUT <= 1'b1;
      O_SDA_OE <= 1'b0;
      unlock_q <= 8'h00;
      ctrl_q <= 8'h00;
      idle_q <= msp_pkg::MSP_IDLE_RST;
      descr_ovr_q <= 1'b0;
      nrzi_ovr_q <= 1'b0;
    end else if (!sel_s || stop_cond) begin
      state_q <= msp_pkg::MSP_IDLE;
      O_SDA_OE <= 1'b0;
      O_SDA_OUT <= 1'b1;
    end else if (start_cond) begin
      state_q <= msp_pkg::MSP_ADDR; // Also repeated start
      bit_cnt_q <= 4'h0;
      byte_idx_q <= 2'h0;
      O_SDA_OE <= 1'b0;
    end else begin
      case (state_q)
        msp_pkg::MSP_ADDR, msp_pkg::MSP_WDATA: begin
          if (sck_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (sck_fall && bit_cnt_q == msp_pkg::MSP_BITS_BYTE) begin
            bit_cnt_q <= 4'h0;
            if (byte_idx_q == 2'h0) begin
              if (shift_q[7:1] == msp_pkg::MSP_TARGET_ADDR) begin
                is_read_q <= shift_q[0];
                O_SDA_OE <= 1'b1;
                O_SDA_OUT <= 1'b0;
                state_q <= msp_pkg::MSP_ACK;
              end else begin
                state_q <= msp_pkg::MSP_IDLE;
              end
            end else begin
              if (byte_idx_q == 2'h1) begin
                reg_addr_q <= shift_q;
              end else if (reg_addr_q == msp_pkg::MSP_REG_CTRL) begin
                ctrl_q <= shift_q;
                descr_ovr_q <= descr_ovr_q | unlock_q[msp_pkg::MSP_BIT_DESCR];
                nrzi_ovr_q <= nrzi_ovr_q | unlock_q[msp_pkg::MSP_BIT_NRZI];
              end else if (reg_addr_q == msp_pkg::MSP_REG_UNLOCK) begin
                unlock_q <= shift_q;
              end else if (reg_addr_q == msp_pkg::MSP_REG_IDLE_CHAR) begin
                idle_q <= shift_q;
              end
              O_SDA_OE <= 1'b1;
              O_SDA_OUT <= 1'b0;
              state_q <= msp_pkg::MSP_ACK;
            end
          end
        end
        msp_pkg::MSP_ACK: begin
          // Release after the acknowledge clock; on a read, drive the first data bit instead
          if (sck_fall) begin
            if (byte_idx_q == 2'h0 && is_read_q) begin
              O_SDA_OE <= !rd_data[7];
              O_SDA_OUT <= 1'b0;
              shift_q <= {rd_data[6:0], 1'b0};
              bit_cnt_q <= 4'h1;
              state_q <= msp_pkg::MSP_RDATA;
            end else begin
              O_SDA_OE <= 1'b0;
              O_SDA_OUT <= 1'b1;
              byte_idx_q <= (byte_idx_q == 2'h2) ? 2'h2 : byte_idx_q + 2'h1;
              state_q <= msp_pkg::MSP_WDATA;
            end
          end
        end
        msp_pkg::MSP_RDATA: begin
          // Open-drain: enable only for a zero
          if (sck_fall) begin
            if (bit_cnt_q == msp_pkg::MSP_BITS_BYTE) begin
              O_SDA_OE <= 1'b0;
              state_q <= msp_pkg::MSP_RACK;
            end else begin
              O_SDA_OE <= !shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        msp_pkg::MSP_RACK: begin
          if (sck_rise) begin
            state_q <= msp_pkg::MSP_IDLE;
          end
        end
        default: begin
          state_q <= msp_pkg::MSP_IDLE;
        end
      endcase
    end
  end
endmodule : msp_core

/* File: design/msp_pkg.sv */
// Package for the mode strap and management port block.
// Assumes a single core clock domain; bus pins arrive asynchronously.
package msp_pkg;
  // Target address on the management bus
  localparam logic [6:0] MSP_TARGET_ADDR = 7'h58;
  // Register offsets
  localparam logic [7:0] MSP_REG_CTRL = 8'h21;
  localparam logic [7:0] MSP_REG_UNLOCK = 8'h22;
  localparam logic [7:0] MSP_REG_IDLE_CHAR = 8'h23;
  localparam logic [7:0] MSP_REG_STATUS = 8'h24;
  // Field positions in control and unlock registers
  localparam int MSP_BIT_DESCR = 5;
  localparam int MSP_BIT_NRZI = 4;
  // Default idle character, K28.5 code groups for negative and positive running disparity
  localparam logic [9:0] MSP_K285_RDN = 10'h0FA;
  localparam logic [9:0] MSP_K285_RDP = 10'h305;
  // Reset values
  localparam logic [7:0] MSP_IDLE_RST = 8'hBC;
  // Bit counter width and byte length
  localparam logic [3:0] MSP_BITS_BYTE = 4'h8;
  // Protocol state type, one-hot
  typedef enum logic [5:0] {
    MSP_IDLE = 6'h01,
    MSP_ADDR = 6'h02,
    MSP_ACK = 6'h04,
    MSP_WDATA = 6'h08,
    MSP_RDATA = 6'h10,
    MSP_RACK = 6'h20
  } msp_state_type;
endpackage : msp_pkg

/* File: design/msp_sync.sv */
// Two-stage synchroniser for one level from outside the core clock.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/1ps
module msp_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q; // First stage, read only by second stage
  // Two flip-flops; idle bus level is high
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : msp_sync

/* File: verification/msp_assertions.sv */
// Port checker for the mode strap and management port block.
// Assumes only the top ports are visible; bound at the foot.
`timescale 1ns/1ps
module msp_assertions (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_MGMT_PORT_SELECT,
  input wire logic I_SCK,
  input wire logic [4:0] I_RAW_LANES,
  input wire logic [7:0] I_DEC_BYTE,
  input wire logic I_DEC_IS_K,
  input wire logic I_DEC_ERR,
  input wire logic I_DEC_STB,
  input wire logic O_SDA_OE,
  input wire logic O_SDA_OUT,
  input wire logic [4:0] O_LANES,
  input wire logic O_REMOTE_SENSE_EN,
  input wire logic O_DC_BALANCE_EN,
  input wire logic O_ALIGN_EN
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  logic [2:0] age_q; // Edges since reset, saturates so modes settle first
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  ////////////////////////////////////////////////////////////
  AST_DESELECT_QUIET: assert property (!I_MGMT_PORT_SELECT [*4] |-> !O_SDA_OE)
    else $error("bus pulled while deselected");
  AST_CODE_ERROR: assert property (O_DC_BALANCE_EN && I_DEC_STB && I_DEC_ERR |=> O_LANES == 5'h1F)
    else $error("code error not coded as all ones");
  AST_SYNC_CHAR: assert property (O_DC_BALANCE_EN && I_DEC_STB && !I_DEC_ERR && I_DEC_IS_K
    && I_DEC_BYTE == 8'hBC |=> O_LANES == 5'h10) else $error("sync not coded");
  AST_DATA_LANES: assert property (O_DC_BALANCE_EN && I_DEC_STB && !I_DEC_ERR && !I_DEC_IS_K
    |=> O_LANES == {1'b0, $past(I_DEC_BYTE[3:0])}) else $error("data lanes wrong");
  AST_RAW_PASS: assert property (age_q == 3'h7 && !O_DC_BALANCE_EN |=> O_LANES == $past(I_RAW_LANES))
    else $error("raw lanes not passed");
  AST_ALIGN_MODE: assert property (age_q > 3'h2 |-> O_ALIGN_EN == (O_REMOTE_SENSE_EN || O_DC_BALANCE_EN))
    else $error("alignment enable wrong");
  AST_MODE_HOLD: assert property (age_q == 3'h7 |-> $stable(O_REMOTE_SENSE_EN) && $stable(O_DC_BALANCE_EN))
    else $error("mode changed after strap capture");
  AST_SDA_LOW_PHASE: assert property ($changed(O_SDA_OE) |-> !I_SCK)
    else $error("data moved while clock high");
  AST_ACK_HELD: assert property ($rose(O_SDA_OE) |=> O_SDA_OE [*4])
    else $error("acknowledge too short");
  AST_OPEN_DRAIN: assert property (O_SDA_OE |-> !O_SDA_OUT)
    else $error("data line driven high");
endmodule : msp_assertions
bind msp_core msp_assertions chk (.I_CORE_CLK, .I_RST_N, .I_MGMT_PORT_SELECT, .I_SCK, .I_RAW_LANES,
  .I_DEC_BYTE, .I_DEC_IS_K, .I_DEC_ERR, .I_DEC_STB, .O_SDA_OE, .O_SDA_OUT, .O_LANES, .O_REMOTE_SENSE_EN,
  .O_DC_BALANCE_EN, .O_ALIGN_EN);

/* File: verification/msp_host_model.sv */
// Management bus host model: drives clock and data, open drain.
// Assumes a pull-up wire outside; SCK idles high between frames.
`timescale 1ns/1ps
module msp_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_sck,
  output logic o_sda
);
  initial begin
    o_sck = 1'b1;
    o_sda = 1'b1;
  end
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // Data changes only with the clock low, eight core clocks a bit
  task bit_x(input logic v, output logic r);
    o_sda <= v;
    tick(2);
    o_sck <= 1'b1;
    tick(3);
    r = i_sda;
    tick(1);
    o_sck <= 1'b0;
    tick(2);
  endtask : bit_x
  // Start and repeated start alike
  task start;
    o_sda <= 1'b1;
    tick(2);
    o_sck <= 1'b1;
    tick(2);
    o_sda <= 1'b0;
    tick(2);
    o_sck <= 1'b0;
    tick(2);
  endtask : start
  task stop;
    o_sda <= 1'b0;
    tick(2);
    o_sck <= 1'b1;
    tick(2);
    o_sda <= 1'b1;
    tick(4);
  endtask : stop
  // Byte MSB first; ninth bit released, so a read ends in not-acknowledge
  task xfer(input logic [7:0] w, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
    bit_x(1'b1, a);
  endtask : xfer
endmodule : msp_host_model

/* File: verification/tb_top.sv */
// Self-checking bench: strap modes, lane coding and management bus.
// Assumes the bound checker and the host model beside the core.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap_sense = 1'b0;
  logic strap_dc = 1'b0;
  logic sel = 1'b0;
  logic standby = 1'b0;
  logic [4:0] raw = 5'h00;
  logic [7:0] dbyte = 8'h00;
  logic is_k = 1'b0;
  logic derr = 1'b0;
  logic stb = 1'b0;
  logic sck, host_sda, sda_oe, sda_out, sda, sense_en, dc_en, al_en, ds_en, nz_en;
  logic [4:0] lanes;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  assign sda = host_sda & ~sda_oe; // Pull-up wire
  msp_core uut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REMOTE_SENSE_DISABLE_N(strap_sense),
    .I_DC_BALANCE_DISABLE_N(strap_dc), .I_MGMT_PORT_SELECT(sel), .I_STANDBY(standby), .I_SCK(sck),
    .I_SDA(sda), .I_RAW_LANES(raw), .I_DEC_BYTE(dbyte), .I_DEC_IS_K(is_k), .I_DEC_ERR(derr),
    .I_DEC_STB(stb), .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .O_LANES(lanes), .O_REMOTE_SENSE_EN(sense_en),
    .O_DC_BALANCE_EN(dc_en), .O_ALIGN_EN(al_en), .O_DESCR_EN(ds_en), .O_NRZI_EN(nz_en));
  msp_host_model host (.i_clk(clk), .i_sda(sda), .o_sck(sck), .o_sda(host_sda));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // Hang guard, far above the run's real length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict;
    end
  end
  task boot(input logic sn, input logic dc);
    @(posedge clk);
    rst_n <= 1'b0;
    strap_sense <= sn;
    strap_dc <= dc;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({sense_en, dc_en, al_en, ds_en, nz_en}, {~sn, ~dc, ~(sn & dc), sn ^ dc, sn ^ dc});
  endtask : boot
  task sym(input logic e, input logic k, input logic [7:0] b, input logic [4:0] exp);
    @(posedge clk);
    derr <= e;
    is_k <= k;
    dbyte <= b;
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    @(negedge clk);
    chk(lanes, exp);
  endtask : sym
  task smb_wr(input logic s, input logic [7:0] ad, input logic [7:0] rg, input logic [7:0] d, input logic na);
    logic [7:0] r;
    logic a;
    @(posedge clk);
    sel <= s;
    host.tick(4);
    host.start;
    host.xfer(ad, r, a);
    chk(a, na);
    host.xfer(rg, r, a);
    chk(a, na);
    host.xfer(d, r, a);
    chk(a, na);
    host.stop;
    sel <= 1'b0;
    host.tick(4);
  endtask : smb_wr
  task smb_rd(input logic [7:0] rg, input logic [7:0] exp);
    logic [7:0] r;
    logic a;
    @(posedge clk);
    sel <= 1'b1;
    host.tick(4);
    host.start;
    host.xfer(8'hB0, r, a);
    chk(a, 1'b0);
    host.xfer(rg, r, a);
    chk(a, 1'b0);
    host.start;
    host.xfer(8'hB1, r, a);
    chk(a, 1'b0);
    host.xfer(8'hFF, r, a);
    host.stop;
    // Select stays high across frames, as for a lone target
    host.tick(4);
    chk(r, exp);
  endtask : smb_rd
  initial begin
    for (int m = 0; m < 4; m++) begin
      boot(m[1], m[0]);
      if (m == 2) begin
        repeat (110) sym(1'b0, 1'b1, 8'hBC, 5'h10);
        sym(1'b1, 1'b0, 8'h00, 5'h1F);
        sym(1'b0, 1'b1, 8'hBC, 5'h10);
        sym(1'b0, 1'b0, 8'h3A, 5'h0A);
        sym(1'b0, 1'b1, 8'hBC, 5'h10);
      end
      if (m == 3) begin
        for (int i = 0; i < 4; i++) begin
          @(posedge clk);
          raw <= i[0] ? 5'h0A : 5'h15;
          @(posedge clk);
          @(negedge clk);
          chk(lanes, i[0] ? 5'h0A : 5'h15);
        end
      end
    end
    @(posedge clk);
    standby <= 1'b1;
    boot(1'b0, 1'b0);
    smb_wr(1'b1, 8'hB0, 8'h22, 8'h20, 1'b0);
    smb_wr(1'b1, 8'hB0, 8'h21, 8'h30, 1'b0);
    @(negedge clk);
    chk({ds_en, nz_en}, 2'b10);
    smb_rd(8'h24, 8'h0F);
    smb_rd(8'h23, 8'hBC);
    smb_wr(1'b1, 8'hB0, 8'h23, 8'h7C, 1'b0);
    smb_rd(8'h23, 8'h7C);
    sym(1'b0, 1'b1, 8'h7C, 5'h10);
    smb_wr(1'b1, 8'hB0, 8'h22, 8'h30, 1'b0);
    smb_wr(1'b1, 8'hB0, 8'h21, 8'h10, 1'b0);
    @(negedge clk);
    chk({ds_en, nz_en}, 2'b01);
    smb_wr(1'b1, 8'hB2, 8'h21, 8'h00, 1'b1);
    smb_wr(1'b0, 8'hB0, 8'h21, 8'h00, 1'b1);
    @(negedge clk);
    chk({ds_en, nz_en}, 2'b01);
    print_verdict;
  end
endmodule : tb_top
